//--- output_clock_realign_and_range.v
`timescale 1ns/10ps
`include "clock_realign_defines.vh"
// How it works
// - Realign pin may assert at any time.
// - Output clock held still while realigning.
// - Hold level set by rate and edge.
// - Asserting may cut one output pulse short.
// - Phase aligns on first falling edge after next rising edge.
// - Output clock restarts after fixed latency.
// - Output codes are 8-bit offset binary.
// - Clip out-of-range input, flag while out.
// - Extended mode takes range from register.
// - Range pin low scales to 133 percent.
// - Negative zero offset differs slightly.
// - Calibration flag high throughout calibration.
// - Over-range covers either output bus.
module output_clock_realign_and_range
#(
	parameter SAMPLE_HALF     = 2,
	parameter LATENCY_SAMPLES = 4,
	parameter CAL_CYCLES      = 1024
)
(
	input  wire        ref_clk_i,
	input  wire        reset_n_i,
	input  wire        output_clock_realign_i,
	input  wire        range_select_pin_i,
	input  wire        ddr_select_pin_i,
	input  wire        edge_select_pin_i,
	input  wire [15:0] sample_i,
	output wire        output_data_clock_o,
	output wire [7:0]  bus_a_o,
	output wire [7:0]  bus_b_o,
	output wire        over_range_o,
	output wire        calibration_active_flag_o,
	output wire        irq_o,
	input  wire        wb_cyc_i,
	input  wire        wb_stb_i,
	input  wire        wb_we_i,
	input  wire [7:0]  wb_adr_i,
	input  wire [3:0]  wb_sel_i,
	input  wire [31:0] wb_dat_i,
	output wire [31:0] wb_dat_o,
	output wire        wb_ack_o
);

	wire        rst_act;
	wire        rst_n;
	wire        hold_raw;
	reg  [2:0]  pin_meta_q;
	reg  [2:0]  pin_q;
	reg  [15:0] div_q;
	wire        samp_rise;
	wire        samp_fall;
	reg  [1:0]  state_q;
	reg  [15:0] lat_q;
	reg         output_data_clock_q;
	reg         hold_seen_q;
	wire        ext;
	wire        ddr;
	wire        edge_inv;
	wire        hold;
	wire        hold_level;
	wire [9:0]  gain;
	wire [7:0]  code;
	wire        over_now;
	reg  [7:0]  bus_a_q;
	reg  [7:0]  bus_b_q;
	reg         ovr_a_q;
	reg         ovr_b_q;
	reg         over_q;
	reg         over_old_q;
	reg         sel_b_q;
	reg         cal_q;
	reg  [15:0] cal_cnt_q;
	reg  [2:0]  ctrl_q;
	reg  [8:0]  fs_adj_q;
	reg  [8:0]  offset_q;
	reg  [3:0]  stat_q;
	reg  [3:0]  mask_q;
	reg         ack_q;
	reg  [31:0] dat_q;
	reg  [31:0] rd_d;
	wire        req;
	wire        wr;
	wire        cal_start;
	wire        align_done;
	wire        cal_done;
	wire [3:0]  events;
	wire [3:0]  w1c;

	realign_sync u_rst_sync
	(
		.clk_i   (ref_clk_i),
		.async_i (~reset_n_i),
		.sync_o  (rst_act)
	);

	assign rst_n = ~rst_act;

	// Assert takes effect with no clock at all
	realign_sync u_realign_sync
	(
		.clk_i   (ref_clk_i),
		.async_i (output_clock_realign_i),
		.sync_o  (hold_raw)
	);

	always @(posedge ref_clk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pin_meta_q <= 3'h0;
			pin_q      <= 3'h0;
		end
		else
		begin
			pin_meta_q <= {edge_select_pin_i, ddr_select_pin_i, range_select_pin_i};
			pin_q      <= pin_meta_q;
		end
	end

	// Sampling clock phases as enables; never reset by realign
	always @(posedge ref_clk_i or negedge rst_n)
	begin
		if (!rst_n)
			div_q <= 16'h0000;
		else if (div_q == 2 * SAMPLE_HALF - 1)
			div_q <= 16'h0000;
		else
			div_q <= div_q + 16'h0001;
	end

	assign samp_rise = (div_q == 16'h0000);
	assign samp_fall = (div_q == SAMPLE_HALF);

	assign ext      = ctrl_q[`CTRL_EXT];
	assign ddr      = ext ? ctrl_q[`CTRL_DDR] : pin_q[1];
	assign edge_inv = ext ? ctrl_q[`CTRL_EDGE] : pin_q[2];

	assign align_done = (state_q == `ST_WAIT) && samp_fall && (lat_q == 16'h0001) && !hold_raw;

	always @(posedge ref_clk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_q <= `ST_RUN;
			lat_q   <= 16'h0000;
			output_data_clock_q  <= 1'b0;
		end
		else
		begin
			case (state_q)
			`ST_RUN:
			begin
				if (hold_raw)
					state_q <= `ST_HOLD;
				else if (ddr ? samp_rise : samp_fall)
					output_data_clock_q <= ~output_data_clock_q;
			end
			`ST_HOLD:
			begin
				if (!hold_raw && samp_rise)
					state_q <= `ST_ARM;
			end
			`ST_ARM:
			begin
				if (hold_raw)
					state_q <= `ST_HOLD;
				else if (samp_fall)
				begin
					output_data_clock_q  <= 1'b0;
					lat_q   <= LATENCY_SAMPLES[15:0];
					state_q <= `ST_WAIT;
				end
			end
			default:
			begin
				if (hold_raw)
					state_q <= `ST_HOLD;
				else if (samp_fall)
				begin
					lat_q <= lat_q - 16'h0001;
					if (lat_q == 16'h0001)
						state_q <= `ST_RUN;
				end
			end
			endcase
		end
	end

	// Forced straight from the async chain, so a short pulse can occur
	assign hold       = hold_raw || (state_q != `ST_RUN);
	assign hold_level = ddr ? edge_inv : ~edge_inv;
	assign output_data_clock_o = hold ? hold_level : (output_data_clock_q ^ edge_inv);

	assign gain = ext ? (`GAIN_EXT_BASE - {3'b000, fs_adj_q[8:2]})
	            : (pin_q[0] ? `GAIN_UNITY : `GAIN_REDUCED);

	sample_coder u_coder
	(
		.sample_i  (sample_i),
		.gain_i    (gain),
		.ofs_mag_i (ext ? offset_q[7:0] : 8'h00),
		.ofs_neg_i (ext && offset_q[`OFS_SIGN]),
		.code_o    (code),
		.over_o    (over_now)
	);

	// One-to-two demux onto alternate buses
	always @(posedge ref_clk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			bus_a_q <= 8'h80;
			bus_b_q <= 8'h80;
			ovr_a_q <= 1'b0;
			ovr_b_q <= 1'b0;
			over_q  <= 1'b0;
			sel_b_q <= 1'b0;
		end
		else if (samp_rise)
		begin
			sel_b_q <= ~sel_b_q;
			if (sel_b_q)
			begin
				bus_b_q <= code;
				ovr_b_q <= over_now;
				over_q  <= over_now | ovr_a_q;
			end
			else
			begin
				bus_a_q <= code;
				ovr_a_q <= over_now;
				over_q  <= over_now | ovr_b_q;
			end
		end
	end

	assign bus_a_o      = bus_a_q;
	assign bus_b_o      = bus_b_q;
	assign over_range_o = over_q;

	assign req       = wb_cyc_i && wb_stb_i;
	assign wr        = req && wb_we_i && ack_q;
	assign cal_start = wr && (wb_adr_i == `ADR_CTRL) && wb_sel_i[0]
	                   && wb_dat_i[`CTRL_CAL];

	// Power-up calibration, rerun on command
	always @(posedge ref_clk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cal_q     <= 1'b1;
			cal_cnt_q <= 16'h0000;
		end
		else if (cal_start)
		begin
			cal_q     <= 1'b1;
			cal_cnt_q <= 16'h0000;
		end
		else if (cal_q)
		begin
			cal_cnt_q <= cal_cnt_q + 16'h0001;
			if (cal_cnt_q == CAL_CYCLES - 1)
				cal_q <= 1'b0;
		end
	end

	assign cal_done = cal_q && !cal_start && (cal_cnt_q == CAL_CYCLES - 1);
	assign calibration_active_flag_o = cal_q;

	always @(posedge ref_clk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			hold_seen_q <= 1'b0;
			over_old_q  <= 1'b0;
		end
		else
		begin
			hold_seen_q <= hold_raw;
			over_old_q  <= over_q;
		end
	end

	// A realign during calibration cannot be refused, only reported
	assign events[`IRQ_OVR]    = over_q && !over_old_q;
	assign events[`IRQ_ALIGN]  = align_done;
	assign events[`IRQ_CAL]    = cal_done;
	assign events[`IRQ_CALHIT] = hold_raw && !hold_seen_q && cal_q;

	assign w1c = (wr && (wb_adr_i == `ADR_IRQ_STAT) && wb_sel_i[0]) ? wb_dat_i[3:0] : 4'h0;

	always @*
	begin
		rd_d = 32'h0000_0000;
		if (wb_adr_i == `ADR_CTRL)
			rd_d[2:0] = ctrl_q;
		else if (wb_adr_i == `ADR_FS_ADJ)
			rd_d[8:0] = fs_adj_q;
		else if (wb_adr_i == `ADR_OFFSET)
			rd_d[8:0] = offset_q;
		else if (wb_adr_i == `ADR_STATUS)
			rd_d[3:0] = {state_q != `ST_RUN, over_q, hold, cal_q};
		else if (wb_adr_i == `ADR_IRQ_STAT)
			rd_d[3:0] = stat_q;
		else if (wb_adr_i == `ADR_IRQ_MASK)
			rd_d[3:0] = mask_q;
	end

	always @(posedge ref_clk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ack_q    <= 1'b0;
			dat_q    <= 32'h0000_0000;
			ctrl_q   <= `CTRL_RST;
			fs_adj_q <= `FS_ADJ_RST;
			offset_q <= `OFFSET_RST;
			stat_q   <= 4'h0;
			mask_q   <= 4'h0;
		end
		else
		begin
			ack_q <= req && !ack_q;
			if (req && !ack_q)
				dat_q <= rd_d;
			// Set wins over a same-cycle clear
			stat_q <= (stat_q & ~w1c) | events;
			if (wr && (wb_adr_i == `ADR_CTRL) && wb_sel_i[0])
				ctrl_q <= wb_dat_i[2:0];
			if (wr && (wb_adr_i == `ADR_FS_ADJ))
			begin
				if (wb_sel_i[0])
					fs_adj_q[7:0] <= wb_dat_i[7:0];
				if (wb_sel_i[1])
					fs_adj_q[8] <= wb_dat_i[8];
			end
			if (wr && (wb_adr_i == `ADR_OFFSET))
			begin
				if (wb_sel_i[0])
					offset_q[7:0] <= wb_dat_i[7:0];
				if (wb_sel_i[1])
					offset_q[8] <= wb_dat_i[8];
			end
			if (wr && (wb_adr_i == `ADR_IRQ_MASK) && wb_sel_i[0])
				mask_q <= wb_dat_i[3:0];
		end
	end

	assign wb_ack_o = ack_q;
	assign wb_dat_o = dat_q;
	assign irq_o    = |(stat_q & mask_q);

endmodule

//--- clock_realign_defines.vh
`ifndef CLOCK_REALIGN_DEFINES_VH
`define CLOCK_REALIGN_DEFINES_VH

// Register byte offsets
`define ADR_CTRL      8'h00
`define ADR_FS_ADJ    8'h04
`define ADR_OFFSET    8'h08
`define ADR_STATUS    8'h0c
`define ADR_IRQ_STAT  8'h10
`define ADR_IRQ_MASK  8'h14

// Control bits
`define CTRL_EXT      0
`define CTRL_DDR      1
`define CTRL_EDGE     2
`define CTRL_CAL      3

// Offset register layout
`define OFS_SIGN      8

// Event bits, shared by status and mask
`define IRQ_W         4
`define IRQ_OVR       0
`define IRQ_ALIGN     1
`define IRQ_CAL       2
`define IRQ_CALHIT    3

// Reset values
`define CTRL_RST      3'h0
`define FS_ADJ_RST    9'h100
`define OFFSET_RST    9'h000

// Gain in 1/256 steps
`define GAIN_UNITY    10'h100
`define GAIN_REDUCED  10'h155
`define GAIN_EXT_BASE 10'h140

// Coding, offsets in 1/16 code steps
`define CODE_MID      17'h0_0080
`define CODE_MAX      17'h0_00ff
`define OFS_NEG_ZERO  10'h002

// Realign sequencer states
`define ST_RUN        2'h0
`define ST_HOLD       2'h1
`define ST_ARM        2'h2
`define ST_WAIT       2'h3

`endif

//--- realign_sync.v
`timescale 1ns/10ps
module realign_sync
(
	input  wire clk_i,
	input  wire async_i,
	output wire sync_o
);

	reg meta_q;
	reg sync_q;

	// Asserts at once, releases only on a clock edge
	always @(posedge clk_i or posedge async_i)
	begin
		if (async_i)
		begin
			meta_q <= 1'b1;
			sync_q <= 1'b1;
		end
		else
		begin
			meta_q <= 1'b0;
			sync_q <= meta_q;
		end
	end

	assign sync_o = sync_q;

endmodule

//--- sample_coder.v
`timescale 1ns/10ps
`include "clock_realign_defines.vh"
module sample_coder
(
	input  wire signed [15:0] sample_i,
	input  wire        [9:0]  gain_i,
	input  wire        [7:0]  ofs_mag_i,
	input  wire               ofs_neg_i,
	output reg         [7:0]  code_o,
	output reg                over_o
);

	wire signed [26:0] prod;
	wire signed [18:0] scaled;
	wire        [9:0]  neg_mag;
	wire signed [9:0]  ofs;
	wire signed [19:0] fine;
	wire signed [16:0] code;

	assign prod    = sample_i * $signed({1'b0, gain_i});
	assign scaled  = prod[26:8];
	// Negative zero is not zero: a small extra step
	assign neg_mag = {2'b00, ofs_mag_i} + `OFS_NEG_ZERO;
	assign ofs     = ofs_neg_i ? -$signed(neg_mag) : $signed({2'b00, ofs_mag_i});
	assign fine    = {scaled[18], scaled} + {{10{ofs[9]}}, ofs};
	// A part-select is unsigned; keep the sign or small negatives clip
	assign code    = $signed(fine[19:4]) + $signed(`CODE_MID);

	always @*
	begin
		over_o = 1'b0;
		code_o = code[7:0];
		if (code < $signed(17'h0_0000))
		begin
			over_o = 1'b1;
			code_o = 8'h00;
		end
		else if (code > $signed(`CODE_MAX))
		begin
			over_o = 1'b1;
			code_o = 8'hff;
		end
	end

endmodule

//--- clock_realign_monitor.sv
`timescale 1ns/10ps
module clock_realign_monitor
#(
	parameter CAL_CYCLES = 1024
)
(
	input logic       ref_clk_i,
	input logic       reset_n_i,
	input logic       output_clock_realign_i,
	input logic       output_data_clock_o,
	input logic [7:0] bus_a_o,
	input logic [7:0] bus_b_o,
	input logic       over_range_o,
	input logic       calibration_active_flag_o,
	input logic       wb_cyc_i,
	input logic       wb_stb_i,
	input logic       wb_ack_o
);
	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (!reset_n_i);
	property p_hold;
		output_clock_realign_i && $past(output_clock_realign_i) |-> $stable(output_data_clock_o);
	endproperty
	a_hold: assert property (p_hold) else $error("clock moved in realign");
	property p_rel;
		$fell(output_clock_realign_i) |-> $stable(output_data_clock_o) [*3];
	endproperty
	a_rel: assert property (p_rel) else $error("early realign release");
	property p_restart;
		$fell(output_clock_realign_i) |-> ##[3:40] $changed(output_data_clock_o);
	endproperty
	a_restart: assert property (p_restart) else $error("clock not restarted");
	property p_clip;
		over_range_o |-> bus_a_o == 8'hff || bus_a_o == 8'h00 || bus_b_o == 8'hff || bus_b_o == 8'h00;
	endproperty
	a_clip: assert property (p_clip) else $error("over flag without clip");
	property p_cal;
		$rose(calibration_active_flag_o) |-> calibration_active_flag_o [*8];
	endproperty
	a_cal: assert property (p_cal) else $error("calibration flag short");
	property p_ack;
		wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
	endproperty
	a_ack: assert property (p_ack) else $error("no bus answer");
	property p_ack_once;
		wb_ack_o |=> !wb_ack_o;
	endproperty
	a_ack_once: assert property (p_ack_once) else $error("ack too long");
	property p_ack_cause;
		wb_ack_o |-> $past(wb_cyc_i && wb_stb_i);
	endproperty
	a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
	cover property ($fell(output_clock_realign_i));
	cover property ($rose(over_range_o));
	cover property ($fell(calibration_active_flag_o));
endmodule

bind output_clock_realign_and_range clock_realign_monitor #(.CAL_CYCLES(CAL_CYCLES)) u_mon
(
	.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i),
	.output_clock_realign_i(output_clock_realign_i), .output_data_clock_o(output_data_clock_o),
	.bus_a_o(bus_a_o), .bus_b_o(bus_b_o), .over_range_o(over_range_o),
	.calibration_active_flag_o(calibration_active_flag_o),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o)
);

//--- realign_driver.sv
`timescale 1ns/10ps
module realign_driver
(
	input  logic       clk_i,
	input  logic       cal_i,
	input  logic       req_i,
	input  logic [3:0] width_i,
	output logic       realign_o
);
	logic       pend_q;
	logic [3:0] cnt_q;
	initial
	begin
		pend_q = 1'b0;
		cnt_q = 4'h0;
		realign_o = 1'b0;
	end
	always @(posedge clk_i)
	begin
		if (req_i)
			pend_q <= 1'b1;
		if (realign_o)
		begin
			cnt_q <= cnt_q + 4'h1;
			if (cnt_q == width_i)
			begin
				realign_o <= 1'b0;
				cnt_q <= 4'h0;
			end
		end
	end
	// Mid-cycle assert, unrelated to the sampling edge
	always @(negedge clk_i)
		if (pend_q && !cal_i && !realign_o)
		begin
			realign_o = 1'b1;
			pend_q = 1'b0;
		end
endmodule

//--- output_clock_realign_and_range_tb.sv
`timescale 1ns/10ps
`include "clock_realign_defines.vh"
module output_clock_realign_and_range_tb;
	logic        clk, rst_n, rng, ddr, edg, cyc, stb, we, req, rl, hl;
	logic        odc, ovr, cal, irq, ack;
	logic [7:0]  adr, ba, bb;
	logic [15:0] smp;
	logic [31:0] wdat, dato;
	logic [8:0]  q;
	int          n_mismatch, num_checks, j, k;
	output_clock_realign_and_range #(.CAL_CYCLES(16)) i_dut
	(
		.ref_clk_i(clk), .reset_n_i(rst_n), .output_clock_realign_i(rl),
		.range_select_pin_i(rng), .ddr_select_pin_i(ddr), .edge_select_pin_i(edg),
		.sample_i(smp), .output_data_clock_o(odc), .bus_a_o(ba), .bus_b_o(bb),
		.over_range_o(ovr), .calibration_active_flag_o(cal), .irq_o(irq),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
		.wb_dat_i(wdat), .wb_dat_o(dato), .wb_ack_o(ack)
	);
	realign_driver i_ctl
	(
		.clk_i(clk), .cal_i(cal), .req_i(req), .width_i(4'h4), .realign_o(rl)
	);
	initial
	begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	task automatic report_and_stop;
		$display("Checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic chk(input logic [8:0] got, input logic [8:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("Error %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wait_n(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [8:0] d);
		int t;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= {23'h00_0000, d};
		t = 0;
		do
		begin
			@(posedge clk);
			t++;
		end
		while (ack !== 1'b1 && t < 20);
		if (ack !== 1'b1)
		begin
			n_mismatch++;
			report_and_stop();
		end
		q = dato[8:0];
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [8:0] e);
		bus(1'b0, a, 9'h000);
		chk(q, e);
	endtask
	task automatic wr(input logic [7:0] a, input logic [8:0] d);
		bus(1'b1, a, d);
	endtask
	task automatic code(input logic [7:0] e, input logic o);
		wait_n(16);
		chk(9'(ba), 9'(e));
		chk(9'(bb), 9'(e));
		chk(9'(ovr), 9'(o));
	endtask
	task automatic cal_wait;
		int t;
		for (t = 0; t < 200 && cal !== 1'b0; t++)
			@(posedge clk);
		if (cal !== 1'b0)
		begin
			n_mismatch++;
			report_and_stop();
		end
	endtask
	initial
	begin
		rst_n = 1'b0;
		rng = 1'b1;
		ddr = 1'b0;
		edg = 1'b0;
		cyc = 1'b0;
		stb = 1'b0;
		we = 1'b0;
		req = 1'b0;
		adr = 8'h00;
		wdat = 32'h0000_0000;
		smp = 16'h0000;
		wait_n(10);
		rst_n <= 1'b1;
		wait_n(2);
		chk(9'(cal), 9'h001);
		cal_wait();
		rd(`ADR_STATUS, 9'h000);
		rd(`ADR_FS_ADJ, 9'h100);
		rd(`ADR_OFFSET, 9'h000);
		rd(8'h18, 9'h000);
		wr(`ADR_IRQ_STAT, 9'h00f);
		wr(`ADR_IRQ_MASK, 9'h00f);
		smp <= 16'h0243;
		code(8'ha4, 1'b0);
		rng <= 1'b0;
		code(8'hb0, 1'b0);
		wr(`ADR_CTRL, 9'h001);
		wr(`ADR_FS_ADJ, 9'h000);
		code(8'had, 1'b0);
		wr(`ADR_FS_ADJ, 9'h100);
		smp <= 16'h0010;
		code(8'h81, 1'b0);
		wr(`ADR_OFFSET, 9'h100);
		code(8'h80, 1'b0);
		wr(`ADR_CTRL, 9'h000);
		smp <= 16'h7fff;
		code(8'hff, 1'b1);
		chk(9'(irq), 9'h001);
		smp <= 16'h8000;
		code(8'h00, 1'b1);
		smp <= 16'h0000;
		code(8'h80, 1'b0);
		rd(`ADR_IRQ_STAT, 9'h001);
		wr(`ADR_IRQ_STAT, 9'h001);
		chk(9'(irq), 9'h000);
		wr(`ADR_IRQ_MASK, 9'h000);
		smp <= 16'h7fff;
		code(8'hff, 1'b1);
		chk(9'(irq), 9'h000);
		rd(`ADR_IRQ_STAT, 9'h001);
		smp <= 16'h0000;
		wr(`ADR_IRQ_STAT, 9'h001);
		wr(`ADR_IRQ_MASK, 9'h00f);
		for (j = 0; j < 4; j++)
		begin
			ddr <= j[1];
			edg <= j[0];
			wait_n(8);
			req <= 1'b1;
			wait_n(1);
			req <= 1'b0;
			wait_n(3);
			hl = ddr ? edg : ~edg;
			chk(9'(odc), 9'(hl));
			rd(`ADR_STATUS, 9'h00a);
			for (k = 0; k < 60 && odc === hl; k++)
				@(posedge clk);
			if (odc === hl)
			begin
				n_mismatch++;
				report_and_stop();
			end
			wait_n(24);
			rd(`ADR_IRQ_STAT, 9'h002);
			wr(`ADR_IRQ_STAT, 9'h002);
		end
		wr(`ADR_CTRL, 9'h008);
		wait_n(2);
		chk(9'(cal), 9'h001);
		req <= 1'b1;
		wait_n(1);
		req <= 1'b0;
		cal_wait();
		wait_n(60);
		rd(`ADR_IRQ_STAT, 9'h006);
		report_and_stop();
	end
endmodule
